// file: rtl/ubm_pkg.sv
// Purpose: Shared constants and types of the endpoint buffer manager
// Assumes: 512-byte endpoint SRAM, eight data endpoints, byte-wide registers
// Notes: Register port address: bit 6 clear selects endpoint bank addr[5:3]
package ubm_pkg;
	localparam int EP_NUM = 8;
	localparam int SRAM_BYTES = 512;
	localparam int PTR_W = 9;
	localparam int CNT_W = 10;
	localparam int MODE_W = 4;
	// Endpoint bank register index, addr[2:0]
	localparam logic [2:0] REG_WPTR_LO = 3'h0;
	localparam logic [2:0] REG_WPTR_HI = 3'h1;
	localparam logic [2:0] REG_RPTR_LO = 3'h2;
	localparam logic [2:0] REG_RPTR_HI = 3'h3;
	localparam logic [2:0] REG_DATA = 3'h4;
	localparam logic [2:0] REG_CNT_LO = 3'h5;
	localparam logic [2:0] REG_CNT_HI = 3'h6;
	localparam logic [2:0] REG_CTRL = 3'h7;
	localparam int BANK_SEL_BIT = 6;
	// Global registers
	localparam logic [7:0] ADDR_CFG = 8'h40;
	localparam logic [7:0] ADDR_ACTIVE = 8'h41;
	localparam logic [7:0] ADDR_BUF_SIZE = 8'h42;
	localparam logic [7:0] ADDR_THRESH = 8'h43;
	localparam logic [7:0] ADDR_STATUS = 8'h44;
	localparam logic [7:0] ADDR_COMMON = 8'h45;
	// Arbiter configuration bits
	localparam int CFG_AUTO = 0;
	localparam int CFG_DMA = 1;
	localparam int CFG_RUN = 2;
	// Reset values
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam logic [7:0] ACTIVE_RST = 8'h00;
	localparam logic [7:0] BUF_SIZE_RST = 8'h08;
	localparam logic [7:0] THRESH_RST = 8'h08;
	localparam logic [7:0] CTRL_RST = 8'h00;

	typedef enum logic [3:0] {
		UBM_MODE_OFF = 4'h0,
		UBM_MODE_NAK = 4'h1,
		UBM_MODE_ACK = 4'h2,
		UBM_MODE_STALL = 4'h3
	} ubm_mode_t;

	typedef enum logic [2:0] {
		UBM_ENG_IDLE = 3'h0,
		UBM_ENG_WAIT = 3'h1,
		UBM_ENG_IN = 3'h2,
		UBM_ENG_OUT = 3'h3,
		UBM_ENG_END = 3'h4
	} ubm_eng_state_t;

	typedef struct packed {
		logic [EP_NUM-1:0][PTR_W-1:0] wptr;
		logic [EP_NUM-1:0][PTR_W-1:0] rptr;
		logic [EP_NUM-1:0][CNT_W-1:0] cnt;
		logic [EP_NUM-1:0][7:0] ctrl;
		logic [2:0] cfg;
		logic [7:0] active;
		logic [7:0] buf_size;
		logic [7:0] thresh;
		logic in_run;
		logic out_run;
		logic started;
		logic [2:0] cur;
		logic [CNT_W-1:0] remain;
		logic [7:0] rdata;
		logic dma_req;
		logic resp_valid;
		logic [MODE_W-1:0] resp_mode;
		logic [CNT_W-1:0] resp_count;
	} ubm_dev_st_t;
endpackage

// file: rtl/ubm_if.sv
// Purpose: Link between buffer manager and serial interface engine
// Assumes: Both ends on one clock
// Notes: Tokens, handshake answer, IN byte stream, OUT byte stream
`timescale 1ns/100ps
interface ubm_if;
	logic tok_valid;
	logic tok_in;
	logic [2:0] tok_ep;
	logic resp_valid;
	logic [ubm_pkg::MODE_W-1:0] resp_mode;
	logic [ubm_pkg::CNT_W-1:0] resp_count;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_data;
	logic tx_last;
	logic rx_valid;
	logic rx_ready;
	logic [7:0] rx_data;
	logic rx_done;
	logic [ubm_pkg::CNT_W-1:0] rx_count;

	modport dev (
		input tok_valid, tok_in, tok_ep, tx_ready, rx_valid, rx_data, rx_done, rx_count,
		output resp_valid, resp_mode, resp_count, tx_valid, tx_data, tx_last, rx_ready
	);
	modport eng (
		output tok_valid, tok_in, tok_ep, tx_ready, rx_valid, rx_data, rx_done, rx_count,
		input resp_valid, resp_mode, resp_count, tx_valid, tx_data, tx_last, rx_ready
	);
endinterface

// file: rtl/ubm_fifo.sv
// Purpose: Small valid/ready buffer, two entries by default
// Assumes: DEPTH is a power of two, at least 2
// Notes: in_ready drops only when full, so no word is lost on a stall
`timescale 1ns/100ps
module ubm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} ubm_fifo_st_t;
	ubm_fifo_st_t st;
	ubm_fifo_st_t next_st;
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic push;
	logic pop;

	// Flags straight from the occupancy count
	assign in_ready = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = mem[st.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers wrap naturally since depth is a power of two
	always_comb
	begin
		next_st = st;
		if (push)
			next_st.wr = st.wr + 1'b1;
		if (pop)
			next_st.rd = st.rd + 1'b1;
		if (push && !pop)
			next_st.cnt = st.cnt + 1'b1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	// Storage needs no reset; the count guards it
	always_ff @(posedge clk)
	begin
		if (push)
			mem[st.wr] <= in_data;
	end
endmodule // ubm_fifo

// file: rtl/ubm_dev.sv
// Purpose: Endpoint buffer manager: SRAM, pointers, counts, data port
// Assumes: One register access per cycle; engine issues one token at a time
// Notes: Read data stand in the cycle after the read strobe only
`timescale 1ns/100ps
module ubm_dev (
	input wire logic clk,
	input wire logic rst_b,
	ubm_if.dev link,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic dma_req
);
	ubm_pkg::ubm_dev_st_t st;
	ubm_pkg::ubm_dev_st_t next_st;
	logic [7:0] sram [0:ubm_pkg::SRAM_BYTES-1];
	logic [2:0] rep;
	logic [2:0] rreg;
	logic is_ep;
	logic auto_mode;
	logic dp_wr;
	logic dp_rd;
	logic [ubm_pkg::PTR_W-1:0] cfill;
	logic [ubm_pkg::PTR_W-1:0] rfill;
	logic [ubm_pkg::PTR_W-1:0] common_base;
	logic [ubm_pkg::PTR_W-1:0] tok_base;
	logic blocked;
	logic start_ok;
	logic push_ok;
	logic push;
	logic f_in_ready;
	logic rx_take;
	logic [8:0] tx_word;
	logic [ubm_pkg::MODE_W-1:0] tok_mode;

	// Base of endpoint n: buffer size times active endpoints below it
	function automatic logic [ubm_pkg::PTR_W-1:0] ep_base(
		input logic [7:0] act,
		input logic [7:0] bsz,
		input logic [3:0] n
	);
		logic [11:0] k;
		k = '0;
		for (int i = 0; i < ubm_pkg::EP_NUM; i++)
			if (4'(i) < n && act[i])
				k = k + 12'h001;
		return ubm_pkg::PTR_W'(k * 12'(bsz));
	endfunction

	// Pointer step; in auto mode leaving the region jumps to the common area
	function automatic logic [ubm_pkg::PTR_W-1:0] next_ptr(
		input logic [ubm_pkg::PTR_W-1:0] p,
		input logic [2:0] n
	);
		logic [ubm_pkg::PTR_W-1:0] lim;
		lim = ep_base(st.active, st.buf_size, {1'b0, n}) + ubm_pkg::PTR_W'(st.buf_size);
		if (auto_mode && st.active[n] && (p + 9'h001) == lim)
			return common_base;
		return p + 9'h001;
	endfunction

	// Address decode
	assign rep = addr[5:3];
	assign rreg = addr[2:0];
	assign is_ep = !addr[ubm_pkg::BANK_SEL_BIT];
	assign auto_mode = st.cfg[ubm_pkg::CFG_AUTO];
	assign dp_wr = wr && is_ep && rreg == ubm_pkg::REG_DATA;
	assign dp_rd = rd && is_ep && rreg == ubm_pkg::REG_DATA;
	assign cfill = st.wptr[st.cur] - st.rptr[st.cur];
	assign rfill = st.wptr[rep] - st.rptr[rep];
	assign common_base = ep_base(st.active, st.buf_size, 4'h8);
	assign tok_base = ep_base(st.active, st.buf_size, {1'b0, link.tok_ep});
	assign blocked = st.out_run && st.cur == rep
		&& !(auto_mode && rfill >= {1'b0, st.thresh});
	assign start_ok = st.started || cfill >= {1'b0, st.thresh}
		|| ubm_pkg::CNT_W'(cfill) >= st.remain;
	assign push_ok = st.in_run && st.remain != '0 && !dp_rd
		&& (!auto_mode || (start_ok && cfill != '0));
	assign push = push_ok && f_in_ready;
	// CPU data port writes own the SRAM write port that cycle
	assign link.rx_ready = st.out_run && !dp_wr;
	assign rx_take = link.rx_valid && link.rx_ready;
	// inactive endpoints answer off in auto mode
	// mask only matters in auto mode
	assign tok_mode = (auto_mode && !st.active[link.tok_ep]) ? ubm_pkg::UBM_MODE_OFF
		: st.ctrl[link.tok_ep][ubm_pkg::MODE_W-1:0];

	// Outputs straight from state
	assign rdata = st.rdata;
	assign dma_req = st.dma_req;
	assign link.resp_valid = st.resp_valid;
	assign link.resp_mode = st.resp_mode;
	assign link.resp_count = st.resp_count;
	assign link.tx_data = tx_word[7:0];
	assign link.tx_last = tx_word[8];

	// Two-entry buffer toward the engine
	ubm_fifo #(
		.WIDTH(9),
		.DEPTH(2)
	) u_tx_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(push),
		.in_ready(f_in_ready),
		.in_data({st.remain == 10'h001, sram[st.rptr[st.cur]]}),
		.out_valid(link.tx_valid),
		.out_ready(link.tx_ready),
		.out_data(tx_word)
	);

	// Next state: register writes, reads, token, streams
	always_comb
	begin
		next_st = st;
		next_st.rdata = 8'h00;
		next_st.resp_valid = 1'b0;
		if (wr && is_ep)
		begin
			case (rreg)
				ubm_pkg::REG_WPTR_LO: if (!auto_mode) next_st.wptr[rep][7:0] = wdata;
				ubm_pkg::REG_WPTR_HI: if (!auto_mode) next_st.wptr[rep][8] = wdata[0];
				ubm_pkg::REG_RPTR_LO: if (!auto_mode) next_st.rptr[rep][7:0] = wdata;
				ubm_pkg::REG_RPTR_HI: if (!auto_mode) next_st.rptr[rep][8] = wdata[0];
				ubm_pkg::REG_DATA: next_st.wptr[rep] = next_ptr(st.wptr[rep], rep);
				ubm_pkg::REG_CNT_LO: next_st.cnt[rep][7:0] = wdata;
				ubm_pkg::REG_CNT_HI: next_st.cnt[rep][9:8] = wdata[1:0];
				ubm_pkg::REG_CTRL: next_st.ctrl[rep] = wdata;
				default: ;
			endcase
		end
		else if (wr)
		begin
			case (addr)
				ubm_pkg::ADDR_CFG: next_st.cfg = wdata[2:0];
				ubm_pkg::ADDR_ACTIVE: if (!st.cfg[ubm_pkg::CFG_RUN]) next_st.active = wdata;
				ubm_pkg::ADDR_BUF_SIZE: if (!st.cfg[ubm_pkg::CFG_RUN]) next_st.buf_size = wdata;
				ubm_pkg::ADDR_THRESH: next_st.thresh = wdata;
				default: ;
			endcase
		end
		if (rd && is_ep)
		begin
			case (rreg)
				ubm_pkg::REG_WPTR_LO: next_st.rdata = st.wptr[rep][7:0];
				ubm_pkg::REG_WPTR_HI: next_st.rdata = {7'h00, st.wptr[rep][8]};
				ubm_pkg::REG_RPTR_LO: next_st.rdata = st.rptr[rep][7:0];
				ubm_pkg::REG_RPTR_HI: next_st.rdata = {7'h00, st.rptr[rep][8]};
				ubm_pkg::REG_DATA:
				begin
					if (!blocked)
					begin
						next_st.rdata = sram[st.rptr[rep]];
						next_st.rptr[rep] = next_ptr(st.rptr[rep], rep);
					end
				end
				ubm_pkg::REG_CNT_LO: next_st.rdata = st.cnt[rep][7:0];
				ubm_pkg::REG_CNT_HI: next_st.rdata = {6'h00, st.cnt[rep][9:8]};
				ubm_pkg::REG_CTRL: next_st.rdata = st.ctrl[rep];
				default: ;
			endcase
		end
		else if (rd)
		begin
			case (addr)
				ubm_pkg::ADDR_CFG: next_st.rdata = {5'h00, st.cfg};
				ubm_pkg::ADDR_ACTIVE: next_st.rdata = st.active;
				ubm_pkg::ADDR_BUF_SIZE: next_st.rdata = st.buf_size;
				ubm_pkg::ADDR_THRESH: next_st.rdata = st.thresh;
				ubm_pkg::ADDR_STATUS: next_st.rdata = {3'h0, common_base[8], st.dma_req,
					st.started, st.out_run, st.in_run};
				ubm_pkg::ADDR_COMMON: next_st.rdata = common_base[7:0];
				default: ;
			endcase
		end
		// Token: answer handshake, open a transfer on ACK
		if (link.tok_valid && !st.in_run && !st.out_run)
		begin
			next_st.resp_valid = 1'b1;
			next_st.resp_mode = tok_mode;
			next_st.resp_count = st.cnt[link.tok_ep];
			if (tok_mode == ubm_pkg::UBM_MODE_ACK)
			begin
				next_st.cur = link.tok_ep;
				next_st.in_run = link.tok_in && st.cnt[link.tok_ep] != '0;
				next_st.out_run = !link.tok_in;
				next_st.remain = st.cnt[link.tok_ep];
				next_st.started = 1'b0;
				// hardware restarts pointers at region base
				if (auto_mode)
				begin
					next_st.wptr[link.tok_ep] = tok_base;
					next_st.rptr[link.tok_ep] = tok_base;
				end
			end
		end
		if (push)
		begin
			next_st.started = 1'b1;
			next_st.rptr[st.cur] = next_ptr(st.rptr[st.cur], st.cur);
			next_st.remain = st.remain - 10'h001;
			if (st.remain == 10'h001)
				next_st.in_run = 1'b0;
		end
		if (rx_take)
			next_st.wptr[st.cur] = next_ptr(st.wptr[st.cur], st.cur);
		if (link.rx_done && st.out_run)
		begin
			next_st.cnt[st.cur] = link.rx_count;
			next_st.out_run = 1'b0;
		end
		next_st.dma_req = st.cfg[ubm_pkg::CFG_DMA] && auto_mode
			&& ((st.in_run && ubm_pkg::CNT_W'(cfill) < st.remain)
			|| (st.out_run && cfill >= {1'b0, st.thresh}));
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= '0;
			st.cfg <= ubm_pkg::CFG_RST;
			st.active <= ubm_pkg::ACTIVE_RST;
			st.buf_size <= ubm_pkg::BUF_SIZE_RST;
			st.thresh <= ubm_pkg::THRESH_RST;
			st.ctrl <= {ubm_pkg::EP_NUM{ubm_pkg::CTRL_RST}};
		end
		else
			st <= next_st;
	end

	// SRAM write port; at most one writer per cycle by construction
	always_ff @(posedge clk)
	begin
		if (dp_wr)
			sram[st.wptr[rep]] <= wdata;
		else if (rx_take)
			sram[st.wptr[st.cur]] <= link.rx_data;
	end
endmodule // ubm_dev

// file: rtl/ubm_eng.sv
// Purpose: Serial engine end: tokens, handshakes, packet byte streams
// Assumes: Bus side logic on the same clock, one token at a time
// Notes: OUT bytes beyond the endpoint maximum are taken and dropped
`timescale 1ns/100ps
module ubm_eng (
	input wire logic clk,
	input wire logic rst_b,
	ubm_if.eng link,
	input wire logic usb_tok_valid,
	input wire logic usb_tok_in,
	input wire logic [2:0] usb_tok_ep,
	output logic usb_hs_valid,
	output logic [ubm_pkg::MODE_W-1:0] usb_hs,
	output logic usb_tx_valid,
	output logic [7:0] usb_tx_data,
	output logic usb_tx_last,
	input wire logic usb_tx_ready,
	input wire logic usb_rx_valid,
	input wire logic [7:0] usb_rx_data,
	input wire logic usb_rx_last,
	output logic usb_rx_ready
);
	typedef struct packed {
		ubm_pkg::ubm_eng_state_t state;
		logic tok_valid;
		logic tok_in;
		logic [2:0] tok_ep;
		logic hs_valid;
		logic [ubm_pkg::MODE_W-1:0] hs;
		logic [ubm_pkg::CNT_W-1:0] max;
		logic [ubm_pkg::CNT_W-1:0] got;
		logic done;
	} ubm_eng_st_t;
	ubm_eng_st_t st;
	ubm_eng_st_t next_st;
	logic f_in_ready;
	logic rx_take;
	logic in_xfer;

	assign in_xfer = st.state == ubm_pkg::UBM_ENG_IN;
	assign usb_rx_ready = st.state == ubm_pkg::UBM_ENG_OUT && f_in_ready;
	assign rx_take = usb_rx_valid && usb_rx_ready;
	// IN bytes pass through; the device buffer absorbs a bus stall
	assign usb_tx_valid = link.tx_valid && in_xfer;
	assign usb_tx_data = link.tx_data;
	assign usb_tx_last = link.tx_last;
	assign link.tx_ready = usb_tx_ready && in_xfer;
	assign link.tok_valid = st.tok_valid;
	assign link.tok_in = st.tok_in;
	assign link.tok_ep = st.tok_ep;
	assign link.rx_done = st.done;
	assign link.rx_count = st.got;
	assign usb_hs_valid = st.hs_valid;
	assign usb_hs = st.hs;

	// Two-entry buffer toward the device
	ubm_fifo #(
		.WIDTH(8),
		.DEPTH(2)
	) u_rx_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(rx_take && st.got != st.max),
		.in_ready(f_in_ready),
		.in_data(usb_rx_data),
		.out_valid(link.rx_valid),
		.out_ready(link.rx_ready),
		.out_data(link.rx_data)
	);

	// Transaction sequencer
	always_comb
	begin
		next_st = st;
		next_st.tok_valid = 1'b0;
		next_st.hs_valid = 1'b0;
		next_st.done = 1'b0;
		case (st.state)
			ubm_pkg::UBM_ENG_IDLE:
			begin
				if (usb_tok_valid)
				begin
					next_st.tok_valid = 1'b1;
					next_st.tok_in = usb_tok_in;
					next_st.tok_ep = usb_tok_ep;
					next_st.state = ubm_pkg::UBM_ENG_WAIT;
				end
			end
			ubm_pkg::UBM_ENG_WAIT:
			begin
				if (link.resp_valid)
				begin
					next_st.hs_valid = 1'b1;
					next_st.hs = link.resp_mode;
					next_st.max = link.resp_count;
					next_st.got = '0;
					if (link.resp_mode != ubm_pkg::UBM_MODE_ACK)
						next_st.state = ubm_pkg::UBM_ENG_IDLE;
					else if (!st.tok_in)
						next_st.state = ubm_pkg::UBM_ENG_OUT;
					else if (link.resp_count == '0)
						next_st.state = ubm_pkg::UBM_ENG_IDLE;
					else
						next_st.state = ubm_pkg::UBM_ENG_IN;
				end
			end
			ubm_pkg::UBM_ENG_IN:
			begin
				if (link.tx_valid && usb_tx_ready && link.tx_last)
					next_st.state = ubm_pkg::UBM_ENG_IDLE;
			end
			ubm_pkg::UBM_ENG_OUT:
			begin
				if (rx_take)
				begin
					if (st.got != st.max)
						next_st.got = st.got + 10'h001;
					if (usb_rx_last)
						next_st.state = ubm_pkg::UBM_ENG_END;
				end
			end
			ubm_pkg::UBM_ENG_END:
			begin
				// report received count once all bytes delivered
				if (!link.rx_valid)
				begin
					next_st.done = 1'b1;
					next_st.state = ubm_pkg::UBM_ENG_IDLE;
				end
			end
			default: next_st.state = ubm_pkg::UBM_ENG_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end
endmodule // ubm_eng

// file: bench/ubm_link_monitor.sv
// Purpose: Checks on the link between buffer manager and serial engine
// Assumes: One clock, reset asynchronous and active low
// Notes: Bytes are counted per token to judge packet lengths
`timescale 1ns/100ps
module ubm_link_monitor (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tok_valid,
	input wire logic tok_in,
	input wire logic resp_valid,
	input wire logic [ubm_pkg::MODE_W-1:0] resp_mode,
	input wire logic [ubm_pkg::CNT_W-1:0] resp_count,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_done,
	input wire logic [ubm_pkg::CNT_W-1:0] rx_count
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic dir_in;
	logic [ubm_pkg::CNT_W-1:0] lim;
	logic [ubm_pkg::CNT_W-1:0] seen;

	// Direction, answered count and moved bytes of the current token
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dir_in <= 1'b0;
			lim <= '0;
			seen <= '0;
		end
		else
		begin
			if (tok_valid)
				dir_in <= tok_in;
			if (resp_valid)
				lim <= resp_count;
			if (tok_valid)
				seen <= '0;
			else if ((tx_valid && tx_ready) || (rx_valid && rx_ready))
				seen <= seen + 1'b1;
		end
	end

	// Token, then exactly one answer pulse
	sequence s_answer;
		##1 resp_valid ##1 !resp_valid;
	endsequence
	sequence s_tx_kept;
		tx_valid && $stable(tx_data) && $stable(tx_last);
	endsequence

	a_tok_answer: assert property (tok_valid |-> s_answer)
		else $error("token without single answer pulse");
	a_resp_cause: assert property (resp_valid |-> $past(tok_valid))
		else $error("answer without token");
	a_mode_code: assert property (resp_valid |-> resp_mode[3:2] == 2'b00)
		else $error("answer mode outside defined codes");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> s_tx_kept)
		else $error("IN byte changed while stalled");
	a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("OUT byte changed while stalled");
	a_tx_dir: assert property (tx_valid |-> dir_in)
		else $error("IN byte offered after OUT token");
	a_rx_dir: assert property (rx_valid |-> !dir_in)
		else $error("OUT byte offered after IN token");
	a_in_count: assert property (tx_valid && tx_ready && tx_last |-> seen + 1'b1 == lim)
		else $error("IN packet length differs from count");
	a_out_count: assert property (rx_done |-> rx_count == seen && rx_count <= lim)
		else $error("received count wrong");
	a_done_quiet: assert property (rx_done |-> !rx_valid)
		else $error("OUT done while bytes still pending");
endmodule // ubm_link_monitor

// file: bench/ubm_tb.sv
// Purpose: Self-checking bench of buffer manager and serial engine together
// Assumes: Register reads answer in the next cycle only
// Notes: Expected results queue up; a watcher pops one per seen result
`timescale 1ns/100ps
module ubm_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic dma_req;
	logic usb_tok_valid = 1'b0;
	logic usb_tok_in = 1'b0;
	logic [2:0] usb_tok_ep = 3'h0;
	logic usb_hs_valid;
	logic [ubm_pkg::MODE_W-1:0] usb_hs;
	logic usb_tx_valid;
	logic [7:0] usb_tx_data;
	logic usb_tx_last;
	logic usb_tx_ready = 1'b0;
	logic usb_rx_valid = 1'b0;
	logic [7:0] usb_rx_data = 8'h00;
	logic usb_rx_last = 1'b0;
	logic usb_rx_ready;
	logic rd_d = 1'b0;
	logic [31:0] seed = 32'h381a2010;
	logic [15:0] rq[$];
	logic [15:0] tq[$];
	logic [15:0] hq[$];
	logic [7:0] pkt[8];
	int error_cnt = 0;
	int checks = 0;
	int w;
	int k;

	ubm_if lnk ();
	ubm_dev ubm_dev_i (.clk(clk), .rst_b(rst_b), .link(lnk.dev), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .dma_req(dma_req));
	ubm_eng ubm_eng_i (.clk(clk), .rst_b(rst_b), .link(lnk.eng), .usb_tok_valid(usb_tok_valid),
		.usb_tok_in(usb_tok_in), .usb_tok_ep(usb_tok_ep), .usb_hs_valid(usb_hs_valid),
		.usb_hs(usb_hs), .usb_tx_valid(usb_tx_valid), .usb_tx_data(usb_tx_data),
		.usb_tx_last(usb_tx_last), .usb_tx_ready(usb_tx_ready), .usb_rx_valid(usb_rx_valid),
		.usb_rx_data(usb_rx_data), .usb_rx_last(usb_rx_last), .usb_rx_ready(usb_rx_ready));
	ubm_link_monitor ubm_link_monitor_i (.clk(clk), .rst_b(rst_b), .tok_valid(lnk.tok_valid),
		.tok_in(lnk.tok_in), .resp_valid(lnk.resp_valid), .resp_mode(lnk.resp_mode),
		.resp_count(lnk.resp_count), .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
		.tx_data(lnk.tx_data), .tx_last(lnk.tx_last), .rx_valid(lnk.rx_valid),
		.rx_ready(lnk.rx_ready), .rx_data(lnk.rx_data), .rx_done(lnk.rx_done),
		.rx_count(lnk.rx_count));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] rb();
		logic [31:0] v;
		v = xs();
		return v[7:0];
	endfunction
	function automatic logic [7:0] ra(input logic [2:0] ep, input logic [2:0] idx);
		return {2'b00, ep, idx};
	endfunction
	// Empty queue yields a value no result can match
	function automatic logic [15:0] pop(ref logic [15:0] q[$]);
		if (q.size() == 0)
			return 16'hffff;
		return q.pop_front();
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tmo();
		error_cnt++;
		$display("BAD %0t wait ran out", $time);
		final_report();
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		rq.push_back({8'h00, e});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic tok(input logic i, input logic [2:0] ep, input logic [3:0] hs);
		hq.push_back({12'h000, hs});
		@(posedge clk);
		usb_tok_valid <= 1'b1;
		usb_tok_in <= i;
		usb_tok_ep <= ep;
		@(posedge clk);
		usb_tok_valid <= 1'b0;
	endtask
	// Waits until every noted result has been seen
	task automatic drain();
		w = 0;
		while ((tq.size() + hq.size() + rq.size()) != 0 && w < 2000)
		begin
			@(negedge clk);
			w++;
		end
		if (w >= 2000)
			tmo();
		repeat (4) @(posedge clk);
	endtask
	// Host bytes held until the engine takes them
	task automatic send_rx(input int n);
		for (k = 0; k < n; k++)
		begin
			pkt[k] = rb();
			usb_rx_valid <= 1'b1;
			usb_rx_data <= pkt[k];
			usb_rx_last <= (k == n - 1);
			w = 0;
			do
			begin
				@(negedge clk);
				w++;
			end
			while (!usb_rx_ready && w < 200);
			if (w >= 200)
				tmo();
			@(posedge clk);
		end
		usb_rx_valid <= 1'b0;
		usb_rx_last <= 1'b0;
	endtask

	// Host side stalls IN bytes about a quarter of the time
	always @(posedge clk)
		usb_tx_ready <= xs() > 32'h40000000;
	always @(posedge clk)
		rd_d <= rd;
	// Watcher: read data, IN bytes and handshakes, settled at mid cycle
	always @(negedge clk)
	begin
		if (rd_d)
			chk({8'h00, rdata}, pop(rq));
		if (usb_tx_valid && usb_tx_ready)
			chk({7'h00, usb_tx_last, usb_tx_data}, pop(tq));
		if (usb_hs_valid)
			chk({12'h000, usb_hs}, pop(hq));
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values, an unmapped place, then the endpoint 5 control reset value
		rreg(ubm_pkg::ADDR_CFG, {5'h00, ubm_pkg::CFG_RST});
		rreg(ubm_pkg::ADDR_BUF_SIZE, ubm_pkg::BUF_SIZE_RST);
		rreg(8'h7f, 8'h00);
		rreg(ra(3'h5, ubm_pkg::REG_CTRL), ubm_pkg::CTRL_RST);
		drain();
		$display("test reset done");
		// Manual IN with an empty activation mask
		wreg(ra(3'h1, ubm_pkg::REG_WPTR_LO), 8'h10);
		wreg(ra(3'h1, ubm_pkg::REG_RPTR_LO), 8'h10);
		for (k = 0; k < 5; k++)
		begin
			pkt[k] = rb();
			wreg(ra(3'h1, ubm_pkg::REG_DATA), pkt[k]);
			tq.push_back({7'h00, k == 4, pkt[k]});
		end
		rreg(ra(3'h1, ubm_pkg::REG_WPTR_LO), 8'h15);
		wreg(ra(3'h1, ubm_pkg::REG_CNT_LO), 8'h05);
		wreg(ra(3'h1, ubm_pkg::REG_CTRL), 8'h02);
		tok(1'b1, 3'h1, ubm_pkg::UBM_MODE_ACK);
		drain();
		$display("test manual in done");
		// Every mode code, empty count so no data follows
		for (k = 0; k < 4; k++)
		begin
			wreg(ra(3'h3, ubm_pkg::REG_CTRL), 8'(k));
			tok(1'b1, 3'h3, 4'(k));
			drain();
		end
		$display("test modes done");
		// Manual OUT, host sends past the maximum
		wreg(ra(3'h2, ubm_pkg::REG_WPTR_HI), 8'h01);
		wreg(ra(3'h2, ubm_pkg::REG_RPTR_HI), 8'h01);
		wreg(ra(3'h2, ubm_pkg::REG_CNT_LO), 8'h04);
		wreg(ra(3'h2, ubm_pkg::REG_CTRL), 8'h02);
		tok(1'b0, 3'h2, ubm_pkg::UBM_MODE_ACK);
		// Packet still arriving, so the port stays shut and the pointer still
		rreg(ra(3'h2, ubm_pkg::REG_DATA), 8'h00);
		send_rx(6);
		w = 0;
		do
		begin
			@(negedge clk);
			w++;
		end
		while (lnk.rx_done !== 1'b1 && w < 200);
		if (w >= 200)
			tmo();
		rreg(ra(3'h2, ubm_pkg::REG_CNT_LO), 8'h04);
		for (k = 0; k < 4; k++)
			rreg(ra(3'h2, ubm_pkg::REG_DATA), pkt[k]);
		rreg(ra(3'h2, ubm_pkg::REG_RPTR_LO), 8'h04);
		drain();
		$display("test manual out done");
		// Auto mode: frozen mask, common base, hardware pointers
		wreg(ubm_pkg::ADDR_CFG, 8'h03);
		wreg(ubm_pkg::ADDR_ACTIVE, 8'h06);
		wreg(ubm_pkg::ADDR_CFG, 8'h07);
		wreg(ubm_pkg::ADDR_ACTIVE, 8'hff);
		rreg(ubm_pkg::ADDR_ACTIVE, 8'h06);
		rreg(ubm_pkg::ADDR_COMMON, 8'h10);
		wreg(ra(3'h5, ubm_pkg::REG_WPTR_LO), 8'h33);
		rreg(ra(3'h5, ubm_pkg::REG_WPTR_LO), 8'h00);
		wreg(ra(3'h4, ubm_pkg::REG_CTRL), 8'h02);
		tok(1'b1, 3'h4, ubm_pkg::UBM_MODE_OFF);
		drain();
		wreg(ra(3'h1, ubm_pkg::REG_CNT_LO), 8'h05);
		tok(1'b1, 3'h1, ubm_pkg::UBM_MODE_ACK);
		drain();
		@(negedge clk);
		chk({15'h0000, dma_req}, 16'h0001);
		for (k = 0; k < 5; k++)
		begin
			pkt[k] = rb();
			tq.push_back({7'h00, k == 4, pkt[k]});
			wreg(ra(3'h1, ubm_pkg::REG_DATA), pkt[k]);
		end
		drain();
		$display("test auto done");
		// Cut-through OUT: first read lands before the done pulse clears the run
		wreg(ubm_pkg::ADDR_THRESH, 8'h02);
		tok(1'b0, 3'h2, ubm_pkg::UBM_MODE_ACK);
		send_rx(4);
		for (k = 0; k < 4; k++)
			rreg(ra(3'h2, ubm_pkg::REG_DATA), pkt[k]);
		drain();
		$display("test auto out done");
		final_report();
	end
endmodule // ubm_tb
